// *** tcc_pkg.sv ***
/*
  tcc_pkg: register offsets, field positions, reset values and mode codes
  for the two-channel timer capture/compare block.
  assumes an APB slave with 32-bit data, one register per aligned word.
*/
package tcc_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TCC_OFS_CTRL0  = 8'h00;
  localparam logic [7:0] TCC_OFS_VALH0  = 8'h04;
  localparam logic [7:0] TCC_OFS_VALL0  = 8'h08;
  localparam logic [7:0] TCC_OFS_CTRL1  = 8'h0c;
  localparam logic [7:0] TCC_OFS_VALH1  = 8'h10;
  localparam logic [7:0] TCC_OFS_VALL1  = 8'h14;
  // ----------------------------------------------------------------
  // control register field positions
  // ----------------------------------------------------------------
  localparam int TCC_BIT_FLAG = 7;
  localparam int TCC_BIT_IE   = 6;
  localparam int TCC_BIT_MSB  = 5;
  localparam int TCC_BIT_MSA  = 4;
  localparam int TCC_BIT_ELSB = 3;
  localparam int TCC_BIT_ELSA = 2;
  localparam int TCC_BIT_TOV  = 1;
  localparam int TCC_BIT_MAX  = 0;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TCC_CTRL_RST = 8'h00;
  localparam logic [1:0] TCC_ELS_OFF  = 2'h0;
  localparam logic [1:0] TCC_ELS_TGL  = 2'h1;
  localparam logic [1:0] TCC_ELS_CLR  = 2'h2;
  localparam logic [1:0] TCC_ELS_SET  = 2'h3;
  localparam logic [15:0] TCC_CNT_RST = 16'h0000;
endpackage

// *** tcc_channels.sv ***
/*
  tcc_channels: both channels of a 16-bit timer, input capture, output
  compare and pwm (buffered and unbuffered), with apb register access.
  assumes the shared counter value and its overflow pulse come from
  logic on pclk; the capture pins come from outside and are synchronised.
*/
// The register offsets and the APB interface to the registers were left to the implementer.
// Overview of operation
// - capture mode: active edge on pin sets the channel event flag
// - compare mode: counter equal to channel value sets the event flag
// - flag clears by read while set then write 0; new event wins
// - writing 1 to flag does nothing; reset clears flag
// - irq raised when flag and enable both set; reset clears enable
// - buffered select bit exists only in channel 0 control
// - buffered select disables channel 1 control, frees channel 1 pin
// - buffered mode runs buffered compare/pwm with edge/level pin action
// - nonzero edge/level: mode-a 1 is compare/pwm, 0 is capture
// - edge/level 00: mode-a sets initial level, 1 low, 0 high
// - capture edges: 01 rising, 10 falling, 11 either
// - compare action: 01 toggle, 10 low, 11 high
// - edge/level 00 disconnects channel, pin is general-purpose
// - toggle-on-wrap toggles pin on overflow in compare mode only
// - overflow action beats compare action when both coincide
// - full-duty force with toggle-on-wrap 0 forces 100% pwm duty
// - full-duty change takes effect from next pwm period
// - value registers hold capture or compare value, undefined at reset
// - capture: high byte read blocks captures until low byte read
// - compare: high byte write blocks compares until low byte written
// - overflow is counter rolling to zero after modulo value
`timescale 1ns/100ps
module tcc_channels
  import tcc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // shared counter
  input  wire logic [15:0] count_value,
  input  wire logic        count_wrap,
  // channel pins
  input  wire logic [1:0]  channel_port_pin_in,
  output logic      [1:0]  channel_port_pin_out,
  output logic      [1:0]  channel_port_pin_oe,
  output logic      [1:0]  channel_pin_owned,
  // interrupt requests
  output logic      [1:0]  channel_irq
);
  import tcc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  ctrl [2];
  logic [15:0] value [2];
  logic [1:0]  flag_armed;
  logic [1:0]  cap_block;
  logic [1:0]  cmp_block;
  logic [1:0]  pin_s1;
  logic [1:0]  pin_s2;
  logic [1:0]  pin_d;
  logic [1:0]  pin_lvl;
  logic [1:0]  max_live;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic at_ofs(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  wire       acc    = psel & penable & pready;
  wire       wr     = acc & pwrite;
  wire       rd     = acc & ~pwrite;
  wire       hit_c0 = at_ofs(paddr, TCC_OFS_CTRL0);
  wire       hit_h0 = at_ofs(paddr, TCC_OFS_VALH0);
  wire       hit_l0 = at_ofs(paddr, TCC_OFS_VALL0);
  wire       hit_c1 = at_ofs(paddr, TCC_OFS_CTRL1);
  wire       hit_h1 = at_ofs(paddr, TCC_OFS_VALH1);
  wire       hit_l1 = at_ofs(paddr, TCC_OFS_VALL1);
  wire       mapped = hit_c0 | hit_h0 | hit_l0 | hit_c1 | hit_h1 | hit_l1;
  wire       buf_on = ctrl[0][TCC_BIT_MSB];
  wire [1:0] hit_c  = {hit_c1 & ~buf_on, hit_c0};
  wire [1:0] hit_h  = {hit_h1, hit_h0};
  wire [1:0] hit_l  = {hit_l1, hit_l0};

  // ----------------------------------------------------------------
  // per-channel decode
  // ----------------------------------------------------------------
  logic [1:0] els [2];
  logic [1:0] active;
  logic [1:0] is_cap;
  logic [1:0] is_cmp;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] cap_evt;
  logic [1:0] match;
  logic [1:0] cmp_evt;
  logic [1:0] evt;
  logic [1:0] clr_ok;
  logic [7:0] rd_ctrl [2];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      els[i]    = {ctrl[i][TCC_BIT_ELSB], ctrl[i][TCC_BIT_ELSA]};
      active[i] = (els[i] != TCC_ELS_OFF) & ~(i == 1 && buf_on);
      is_cap[i] = active[i] & ~ctrl[i][TCC_BIT_MSA] & ~((i == 0) & buf_on);
      is_cmp[i] = active[i] & ~is_cap[i];
      rise[i]   = pin_s2[i] & ~pin_d[i];
      fall[i]   = ~pin_s2[i] & pin_d[i];
      cap_evt[i] = is_cap[i] & ~cap_block[i] &
                   ((els[i][0] & rise[i]) | (els[i][1] & fall[i]));
      match[i]   = count_value == value[i];
      cmp_evt[i] = is_cmp[i] & ~cmp_block[i] & match[i];
      evt[i]     = cap_evt[i] | cmp_evt[i];
      clr_ok[i]  = wr & hit_c[i] & ~pwdata[TCC_BIT_FLAG] & flag_armed[i];
      rd_ctrl[i] = ctrl[i];
    end
    rd_ctrl[0][TCC_BIT_MSB] = buf_on;
    rd_ctrl[1][TCC_BIT_MSB] = 1'b0;
  end

  // ----------------------------------------------------------------
  // pin action per channel
  // ----------------------------------------------------------------
  function automatic logic pin_next(input logic cur, input logic [1:0] e,
                                    input logic cmp, input logic wrap,
                                    input logic tov, input logic force_hi);
    logic r;
    r = cur;
    if (tov && wrap) begin
      r = ~cur;
    end else if (force_hi) begin
      r = 1'b1;
    end else if (cmp) begin
      unique case (e)
        TCC_ELS_TGL: r = ~cur;
        TCC_ELS_CLR: r = 1'b0;
        TCC_ELS_SET: r = 1'b1;
        default:     r = cur;
      endcase
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next pin level and full-duty latch
  // ----------------------------------------------------------------
  logic [1:0] next_lvl;
  logic [1:0] next_max;
  logic [1:0] cmp_hit;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_max[i] = count_wrap ? ctrl[i][TCC_BIT_MAX] & ~ctrl[i][TCC_BIT_TOV]
                               : max_live[i];
      cmp_hit[i]  = is_cmp[i] & ~cmp_block[i] & match[i];
      if (!active[i]) begin
        next_lvl[i] = ~ctrl[i][TCC_BIT_MSA];
      end else if (is_cmp[i]) begin
        next_lvl[i] = pin_next(pin_lvl[i], els[i], cmp_hit[i], count_wrap,
                               ctrl[i][TCC_BIT_TOV], max_live[i]);
      end else begin
        next_lvl[i] = pin_lvl[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_d  <= 2'h0;
    end else begin
      pin_s1 <= channel_port_pin_in;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // ----------------------------------------------------------------
  // control and flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl[0]    <= TCC_CTRL_RST;
      ctrl[1]    <= TCC_CTRL_RST;
      flag_armed <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr && hit_c[i]) begin
          ctrl[i][6:0] <= pwdata[6:0];
          if (i == 1) begin
            ctrl[i][TCC_BIT_MSB] <= 1'b0;
          end
        end
        if (evt[i]) begin
          ctrl[i][TCC_BIT_FLAG] <= 1'b1;                   // set wins
          flag_armed[i]         <= 1'b0;
        end else if (clr_ok[i]) begin
          ctrl[i][TCC_BIT_FLAG] <= 1'b0;
          flag_armed[i]         <= 1'b0;
        end else if (rd && hit_c[i] && ctrl[i][TCC_BIT_FLAG]) begin
          flag_armed[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // channel value registers, no reset on data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 2; i++) begin
      if (cap_evt[i]) begin
        value[i] <= count_value;
      end else begin
        if (wr && hit_h[i]) begin
          value[i][15:8] <= pwdata[7:0];
        end
        if (wr && hit_l[i]) begin
          value[i][7:0] <= pwdata[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // coupled byte access blocks
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_block <= 2'h0;
      cmp_block <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rd && hit_l[i]) begin
          cap_block[i] <= 1'b0;
        end else if (rd && hit_h[i] && is_cap[i]) begin
          cap_block[i] <= 1'b1;
        end
        if (wr && hit_l[i]) begin
          cmp_block[i] <= 1'b0;
        end else if (wr && hit_h[i] && ~is_cap[i]) begin
          cmp_block[i] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pin level and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_lvl              <= 2'h3;
      channel_port_pin_out <= 2'h0;
    end else begin
      pin_lvl              <= next_lvl;
      channel_port_pin_out <= next_lvl;
    end
  end

  // ----------------------------------------------------------------
  // full-duty latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_live <= 2'h0;
    end else begin
      max_live <= next_max;
    end
  end

  // ----------------------------------------------------------------
  // pin ownership
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_port_pin_oe <= 2'h0;
      channel_pin_owned   <= 2'h0;
    end else begin
      channel_port_pin_oe <= is_cmp;
      channel_pin_owned   <= active;
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_irq <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        channel_irq[i] <= ctrl[i][TCC_BIT_FLAG] & ctrl[i][TCC_BIT_IE] &
                          ~((i == 1) & buf_on);
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read data
  // ----------------------------------------------------------------
  logic [7:0] next_rd;

  always_comb begin
    next_rd = 8'h00;
    if (hit_c0) next_rd = rd_ctrl[0];
    if (hit_c1) next_rd = buf_on ? 8'h00 : rd_ctrl[1];
    if (hit_h0) next_rd = value[0][15:8];
    if (hit_l0) next_rd = value[0][7:0];
    if (hit_h1) next_rd = value[1][15:8];
    if (hit_l1) next_rd = value[1][7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= {24'h00_0000, next_rd};
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
    end
  end
endmodule

// *** tcc_far_model.sv ***
/* tcc_far_model: shared counter and external pins in front of the channels.
   assumes the bench requests pin levels on pin_req. */
`timescale 1ns/100ps
module tcc_far_model #(parameter logic [15:0] MODULO = 16'h00ff) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bench request
  input  wire logic [1:0]  pin_req,
  input  wire logic        counter_halt,
  // far side outputs
  output logic      [15:0] count_value,
  output logic             count_wrap,
  output logic      [1:0]  pin_level
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= 16'h0000;
      count_wrap  <= 1'b0;
      pin_level   <= 2'h0;
    end else begin
      // stop and reset together hold the count at zero
      count_wrap  <= ~counter_halt & (count_value == MODULO);
      count_value <= (counter_halt || count_value == MODULO) ? 16'h0000 :
                     count_value + 16'h0001;
      pin_level   <= pin_req;
    end
  end
endmodule

// *** tcc_channels_props.sv ***
/* tcc_channels_props: port assertions for tcc_channels.
   assumes one clock pclk and async active-low presetn. */
`timescale 1ns/100ps
module tcc_channels_props (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and irq
  input wire logic [1:0]  channel_port_pin_in,
  input wire logic [1:0]  channel_port_pin_oe,
  input wire logic [1:0]  channel_pin_owned,
  input wire logic [1:0]  channel_irq
);
  logic [3:0] since_chg;
  logic       last_pin;
  wire        wr_done = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since channel 1 pin moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pin  <= 1'b0;
      since_chg <= 4'hf;
    end else begin
      last_pin  <= channel_port_pin_in[1];
      since_chg <= (channel_port_pin_in[1] != last_pin) ? 4'h0 :
                   (since_chg == 4'hf) ? 4'hf : since_chg + 4'h1;
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  setup_answer_a: assert property (setup_s |=> access_s)
    else $error("setup unanswered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data");
  owned_oe_a: assert property ((channel_port_pin_oe & ~channel_pin_owned) == 2'h0)
    else $error("released pin driven");
  oe_by_write_a: assert property ($changed(channel_port_pin_oe) |->
    $past(wr_done) || $past(wr_done, 2)) else $error("enable moved alone");
  irq_clear_a: assert property (|($past(channel_irq) & ~channel_irq) |->
    $past(wr_done) || $past(wr_done, 2)) else $error("irq dropped alone");
  irq_capture_a: assert property ($rose(channel_irq[1]) && !channel_port_pin_oe[1] |->
    since_chg <= 4'h8) else $error("capture without edge");
endmodule
bind tcc_channels tcc_channels_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .channel_port_pin_in(channel_port_pin_in), .channel_port_pin_oe(channel_port_pin_oe),
  .channel_pin_owned(channel_pin_owned), .channel_irq(channel_irq));

// *** test_timer_channel_capture_compare.sv ***
/* test_timer_channel_capture_compare: self-checking bench for tcc_channels.
   assumes tcc_far_model drives counter and pins. */
`timescale 1ns/100ps
module test_timer_channel_capture_compare;
  import tcc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        halt = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, count_wrap, p;
  logic [15:0] count_value, v;
  logic [1:0]  pin_req = 2'h0, pin_in, pin_out, pin_oe, owned, irq, els;
  logic [8:0]  note, exp_q[$];
  int          error_cnt = 0, n_checks = 0, cycles = 0;
  int unsigned r;
  always #20 pclk = ~pclk;
  tcc_far_model u_far (.pclk(pclk), .presetn(presetn), .pin_req(pin_req), .counter_halt(halt),
    .count_value(count_value), .count_wrap(count_wrap), .pin_level(pin_in));
  tcc_channels DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_value(count_value), .count_wrap(count_wrap),
    .channel_port_pin_in(pin_in), .channel_port_pin_out(pin_out),
    .channel_port_pin_oe(pin_oe), .channel_pin_owned(owned), .channel_irq(irq));
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic mode_wr(input logic [7:0] a, input logic [7:0] d);
    halt <= 1'b1;
    apb(1'b1, a, d);
    halt <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic wait_for(input int w);
    do begin
      @(posedge pclk);
    end while ((w == 2 ? count_wrap : irq[w]) !== 1'b1);
    repeat (2) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      summarize();
    end
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      chk("prdata", note[7:0], prdata[7:0]);
      chk("pslverr", {7'h0, note[8]}, {7'h0, pslverr});
    end
  end
  initial begin
    r = $urandom(80137);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(TCC_OFS_CTRL0, 9'h000);
    rd(8'h18, 9'h100);
    apb(1'b1, TCC_OFS_CTRL0, 8'h80);
    rd(TCC_OFS_CTRL0, 9'h000);
    apb(1'b1, TCC_OFS_CTRL1, 8'h20);
    rd(TCC_OFS_CTRL1, 9'h000);
    mode_wr(TCC_OFS_CTRL0, 8'h10);
    chk("pin0", 8'h00, {7'h0, pin_out[0]});
    chk("owned0", 8'h00, {7'h0, owned[0]});
    mode_wr(TCC_OFS_CTRL0, 8'h00);
    chk("pin0", 8'h01, {7'h0, pin_out[0]});
    $display("test reset_preset done");
    v = 16'($urandom_range(240, 16));
    apb(1'b1, TCC_OFS_VALH0, v[15:8]);
    apb(1'b1, TCC_OFS_VALL0, v[7:0]);
    for (int i = 0; i < 3; i++) begin
      els = (i == 1) ? TCC_ELS_SET : (i == 2) ? TCC_ELS_TGL : TCC_ELS_CLR;
      mode_wr(TCC_OFS_CTRL0, {4'h5, els, 2'h0});
      wait_for(0);
      chk("pin0", {7'h0, i[0]}, {7'h0, pin_out[0]});
      chk("oe0", 8'h01, {7'h0, pin_oe[0]});
      rd(TCC_OFS_CTRL0, {1'b0, 4'hd, els, 2'h0});
    end
    apb(1'b1, TCC_OFS_CTRL0, 8'h00);
    rd(TCC_OFS_CTRL0, 9'h000);
    $display("test compare done");
    for (int e = 1; e < 4; e++) begin
      pin_req <= 2'h0;
      repeat (3) @(posedge pclk);
      mode_wr(TCC_OFS_CTRL1, {4'h4, 2'(e), 2'h0});
      pin_req <= 2'h2;
      repeat (8) @(posedge pclk);
      rd(TCC_OFS_CTRL1, {1'b0, e[0], 3'h4, 2'(e), 2'h0});
      chk("irq1", {7'h0, e[0]}, {7'h0, irq[1]});
      chk("oe1", 8'h00, {7'h0, pin_oe[1]});
      apb(1'b1, TCC_OFS_CTRL1, {4'h4, 2'(e), 2'h0});
      pin_req <= 2'h0;
      repeat (8) @(posedge pclk);
      rd(TCC_OFS_CTRL1, {1'b0, e[1], 3'h4, 2'(e), 2'h0});
      apb(1'b1, TCC_OFS_CTRL1, {4'h4, 2'(e), 2'h0});
    end
    apb(1'b0, TCC_OFS_VALH1, 8'h00);
    pin_req <= 2'h2;
    repeat (8) @(posedge pclk);
    rd(TCC_OFS_CTRL1, 9'h04c);
    apb(1'b0, TCC_OFS_VALL1, 8'h00);
    pin_req <= 2'h0;
    repeat (8) @(posedge pclk);
    rd(TCC_OFS_CTRL1, 9'h0cc);
    apb(1'b1, TCC_OFS_CTRL1, 8'h4c);
    $display("test capture done");
    mode_wr(TCC_OFS_CTRL0, 8'h20);
    rd(TCC_OFS_CTRL0, 9'h020);
    chk("owned1", 8'h00, {7'h0, owned[1]});
    apb(1'b1, TCC_OFS_CTRL1, 8'h44);
    rd(TCC_OFS_CTRL1, 9'h000);
    $display("test buffered done");
    apb(1'b1, TCC_OFS_VALH0, 8'hff);
    apb(1'b1, TCC_OFS_VALL0, 8'hff);
    mode_wr(TCC_OFS_CTRL0, 8'h16);
    rd(TCC_OFS_CTRL1, 9'h04c);
    wait_for(2);
    p = pin_out[0];
    wait_for(2);
    chk("pin0", {7'h0, ~p}, {7'h0, pin_out[0]});
    $display("test wrap_toggle done");
    summarize();
  end
endmodule
